/* File: area_decoder_bus_width.sv */
// area decoder, chip selects and bus width splitting of the bus controller
`timescale 1ns/1ns
`default_nettype none
`include "area_decode_consts.svh"

module area_decoder_bus_width
    import area_decode_pkg::*;
(
    // clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    // cpu request
    input  wire logic        req_valid,
    input  wire logic [31:0] req_addr,
    input  wire size_type    req_size,
    input  wire logic        req_write,
    input  wire logic [31:0] req_wdata,
    // cpu answer
    output logic             req_busy,
    output logic             req_done,
    output logic      [31:0] req_rdata,
    // configuration
    input  wire logic [2:0]  boot_config_pins,
    input  wire logic        dram_area_enable,
    input  wire logic        muxed_io_enable,
    // external bus
    output logic      [7:0]  area_select_n,
    output logic      [21:0] ext_addr,
    output logic      [1:0]  dram_addr_hi,
    output logic             dram_strobe_en,
    output logic             muxed_io_cycle,
    output logic             bus_write,
    output logic      [1:0]  lane_active,
    output logic      [15:0] addr_data_out,
    output logic      [15:0] addr_data_oe,
    input  wire logic [15:0] addr_data_in,
    input  wire logic        beat_ack,
    // on-chip spaces
    output logic             rom_sel,
    output logic             periph_sel,
    output logic             ram_sel,
    output logic      [15:0] onchip_addr,
    output logic      [31:0] onchip_wdata,
    input  wire logic [31:0] onchip_rdata
);

    // last beat index for a transfer size on a bus width
    function automatic logic [1:0] last_beat_of(width_type w, size_type s);
        logic [1:0] n;
        n = 2'd0;
        if (w == WIDTH_8) begin
            n = (s == SIZE_LONG) ? 2'd3 : (s == SIZE_WORD) ? 2'd1 : 2'd0;
        end else if (w == WIDTH_16) begin
            n = (s == SIZE_LONG) ? 2'd1 : 2'd0;
        end
        return n;
    endfunction

    function automatic logic is_external(space_type sp);
        return (sp == SPACE_EXT) || (sp == SPACE_MUXIO) ||
               (sp == SPACE_DRAM);
    endfunction

    state_type   state_reg;
    logic [27:0] addr_reg;
    size_type    size_reg;
    logic        write_reg;
    logic [31:0] wdata_reg;
    logic [1:0]  beat_reg;
    logic [1:0]  last_reg;
    logic [31:0] acc_reg;

    logic [7:0]  area_select_n_reg;
    logic [21:0] ext_addr_reg;
    logic [1:0]  dram_addr_hi_reg;
    logic        dram_strobe_en_reg;
    logic        muxed_io_cycle_reg;
    logic        bus_write_reg;
    logic [1:0]  lane_active_reg;
    logic [15:0] addr_data_out_reg;
    logic [15:0] addr_data_oe_reg;
    logic        rom_sel_reg;
    logic        periph_sel_reg;
    logic        ram_sel_reg;
    logic [15:0] onchip_addr_reg;
    logic [31:0] onchip_wdata_reg;
    logic        req_busy_reg;
    logic        req_done_reg;
    logic [31:0] req_rdata_reg;

    logic [2:0]  area;
    space_type   space;
    width_type   width;
    logic [15:0] lane_out;
    logic [1:0]  lane_mask;
    logic [1:0]  remain;
    logic [1:0]  last_now;
    logic [2:0]  beat_offset;
    logic [21:0] beat_addr;
    logic [7:0]  cs_next;
    logic [15:0] onchip_addr_next;
    logic [15:0] chunk;
    logic [31:0] acc_next;
    logic        beat_done;
    logic        last_beat;

    // only bits 27..0 enter the decoder; 31..28 are dropped at request capture
    area_classify u_classify (
        .addr             (addr_reg),
        .boot_config_pins (boot_config_pins),
        .dram_area_enable (dram_area_enable),
        .muxed_io_enable  (muxed_io_enable),
        .area             (area),
        .space            (space),
        .width            (width)
    );

    lane_router u_lanes (
        .width     (width),
        .size      (size_reg),
        .addr_lsb  (addr_reg[0]),
        .remain    (remain),
        .wdata     (wdata_reg),
        .lane_out  (lane_out),
        .lane_mask (lane_mask)
    );

    // last_reg still holds the prior request during the first setup
    assign last_now  = (beat_reg == 2'd0) ? last_beat_of(width, size_reg)
                                          : last_reg;
    assign remain    = last_now - beat_reg;
    assign beat_done = (state_reg == ST_BEAT) && beat_ack;
    assign last_beat = (beat_reg == last_reg);

    // beats advance by the bus width; bit 27 never enters the address
    always_comb begin
        beat_offset = (width == WIDTH_16) ? {beat_reg, 1'b0}
                                          : {1'b0, beat_reg};
        beat_addr   = addr_reg[21:0] + {19'h0, beat_offset};
    end

    always_comb begin
        cs_next = `CS_IDLE;
        if (space == SPACE_EXT || space == SPACE_MUXIO) begin
            cs_next[area] = 1'b0;
        end
    end

    always_comb begin
        onchip_addr_next = 16'h0000;
        case (space)
            SPACE_ROM: begin
                onchip_addr_next = beat_addr[`ROM_ADDR_W-1:0];
            end
            SPACE_PERIPH: begin
                onchip_addr_next = {7'h00,
                                    beat_addr[`PERIPH_ADDR_W-1:0]};
            end
            SPACE_RAM: begin
                onchip_addr_next = {4'h0, beat_addr[`RAM_ADDR_W-1:0]};
            end
            default: begin
                onchip_addr_next = 16'h0000;
            end
        endcase
    end

    // gather read data; on 16-bit byte reads the even byte is the high lane
    always_comb begin
        chunk    = is_external(space) ? addr_data_in : onchip_rdata[15:0];
        acc_next = acc_reg;
        if (width == WIDTH_32) begin
            acc_next = onchip_rdata;
        end else if (width == WIDTH_8) begin
            acc_next = {acc_reg[23:0], chunk[7:0]};
        end else if (size_reg == SIZE_BYTE) begin
            acc_next = {24'h0, addr_reg[0] ? chunk[7:0] : chunk[15:8]};
        end else begin
            acc_next = {acc_reg[15:0], chunk};
        end
    end

    // sequencer: the request is held until its last beat is acknowledged
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            beat_reg  <= 2'd0;
        end else if (clk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    if (req_valid) begin
                        state_reg <= ST_SETUP;
                        beat_reg  <= 2'd0;
                    end
                end
                ST_SETUP: begin
                    state_reg <= ST_BEAT;
                end
                ST_BEAT: begin
                    if (beat_ack) begin
                        if (last_beat) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            state_reg <= ST_SETUP;
                            beat_reg  <= beat_reg + 2'd1;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // request capture; requests seen while busy are ignored
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            addr_reg  <= 28'h0000000;
            size_reg  <= SIZE_BYTE;
            write_reg <= 1'b0;
            wdata_reg <= 32'h00000000;
        end else if (clk_en && state_reg == ST_IDLE && req_valid) begin
            addr_reg  <= req_addr[27:0];
            size_reg  <= req_size;
            write_reg <= req_write;
            wdata_reg <= req_wdata;
        end
    end

    // last beat index is fixed once decode settles in the first setup
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            last_reg <= 2'd0;
        end else if (clk_en && state_reg == ST_SETUP && beat_reg == 2'd0) begin
            last_reg <= last_beat_of(width, size_reg);
        end
    end

    // bus outputs load in setup; all but ext_addr and addr_data_out drop on the last acknowledge
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            area_select_n_reg  <= `CS_IDLE;
            ext_addr_reg       <= 22'h000000;
            dram_addr_hi_reg   <= 2'b00;
            dram_strobe_en_reg <= 1'b0;
            muxed_io_cycle_reg <= 1'b0;
            bus_write_reg      <= 1'b0;
            lane_active_reg    <= 2'b00;
            addr_data_out_reg  <= 16'h0000;
            addr_data_oe_reg   <= 16'h0000;
        end else if (clk_en) begin
            if (state_reg == ST_SETUP) begin
                area_select_n_reg  <= cs_next;
                ext_addr_reg       <= is_external(space) ? beat_addr
                                                         : 22'h000000;
                dram_addr_hi_reg   <= (space == SPACE_DRAM) ?
                    addr_reg[`DRAM_HI_MSB:`DRAM_HI_LSB] : 2'b00;
                dram_strobe_en_reg <= (space == SPACE_DRAM);
                muxed_io_cycle_reg <= (space == SPACE_MUXIO);
                bus_write_reg      <= write_reg && is_external(space);
                lane_active_reg    <= is_external(space) ? lane_mask
                                                         : 2'b00;
                addr_data_out_reg  <= lane_out;
                addr_data_oe_reg   <= (write_reg && is_external(space)) ?
                    {{8{lane_mask[1]}}, {8{lane_mask[0]}}} :
                    16'h0000;
            end else if (beat_done && last_beat) begin
                area_select_n_reg  <= `CS_IDLE;
                dram_addr_hi_reg   <= 2'b00;
                dram_strobe_en_reg <= 1'b0;
                muxed_io_cycle_reg <= 1'b0;
                bus_write_reg      <= 1'b0;
                lane_active_reg    <= 2'b00;
                addr_data_oe_reg   <= 16'h0000;
            end
        end
    end

    // on-chip selects; these spaces never touch the area selects
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rom_sel_reg      <= 1'b0;
            periph_sel_reg   <= 1'b0;
            ram_sel_reg      <= 1'b0;
            onchip_addr_reg  <= 16'h0000;
            onchip_wdata_reg <= 32'h00000000;
        end else if (clk_en) begin
            if (state_reg == ST_SETUP) begin
                rom_sel_reg      <= (space == SPACE_ROM);
                periph_sel_reg   <= (space == SPACE_PERIPH);
                ram_sel_reg      <= (space == SPACE_RAM);
                onchip_addr_reg  <= onchip_addr_next;
                onchip_wdata_reg <= (width == WIDTH_32) ? wdata_reg
                                                        : {16'h0000, lane_out};
            end else if (beat_done && last_beat) begin
                rom_sel_reg    <= 1'b0;
                periph_sel_reg <= 1'b0;
                ram_sel_reg    <= 1'b0;
            end
        end
    end

    // answer to the cpu
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            acc_reg       <= 32'h00000000;
            req_busy_reg  <= 1'b0;
            req_done_reg  <= 1'b0;
            req_rdata_reg <= 32'h00000000;
        end else if (clk_en) begin
            req_done_reg <= 1'b0;
            if (state_reg == ST_IDLE && req_valid) begin
                acc_reg      <= 32'h00000000;
                req_busy_reg <= 1'b1;
            end else if (beat_done) begin
                acc_reg <= acc_next;
                if (last_beat) begin
                    req_busy_reg  <= 1'b0;
                    req_done_reg  <= 1'b1;
                    req_rdata_reg <= write_reg ? req_rdata_reg : acc_next;
                end
            end
        end
    end

    assign area_select_n  = area_select_n_reg;
    assign ext_addr       = ext_addr_reg;
    assign dram_addr_hi   = dram_addr_hi_reg;
    assign dram_strobe_en = dram_strobe_en_reg;
    assign muxed_io_cycle = muxed_io_cycle_reg;
    assign bus_write      = bus_write_reg;
    assign lane_active    = lane_active_reg;
    assign addr_data_out  = addr_data_out_reg;
    assign addr_data_oe   = addr_data_oe_reg;
    assign rom_sel        = rom_sel_reg;
    assign periph_sel     = periph_sel_reg;
    assign ram_sel        = ram_sel_reg;
    assign onchip_addr    = onchip_addr_reg;
    assign onchip_wdata   = onchip_wdata_reg;
    assign req_busy       = req_busy_reg;
    assign req_done       = req_done_reg;
    assign req_rdata      = req_rdata_reg;

    a_idle_cs_high: assert property (@(posedge mclk) disable iff (!rst_b)
        state_reg == ST_IDLE |-> area_select_n == `CS_IDLE)
        else $error("area select low while idle");

    a_cs_one_hot: assert property (@(posedge mclk) disable iff (!rst_b)
        state_reg == ST_BEAT && is_external(space) && space != SPACE_DRAM
        |-> area_select_n == ~(8'h01 << addr_reg[26:24]))
        else $error("area select does not match address bits 26..24");

    a_onchip_no_cs: assert property (@(posedge mclk) disable iff (!rst_b)
        rom_sel || periph_sel || ram_sel |-> area_select_n == `CS_IDLE)
        else $error("area select driven for an on-chip access");

    a_dram_no_cs: assert property (@(posedge mclk) disable iff (!rst_b)
        dram_strobe_en |-> area_select_n[1] && addr_reg[26:24] == 3'h1)
        else $error("dram access drove area 1 select");

    a_narrow_lanes: assert property (@(posedge mclk) disable iff (!rst_b)
        state_reg == ST_BEAT && width == WIDTH_8
        |-> addr_data_oe[15:8] == 8'h00)
        else $error("upper lanes driven on an 8-bit bus");

    a_even_byte_high: assert property (@(posedge mclk) disable iff (!rst_b)
        state_reg == ST_BEAT && width == WIDTH_16 && size_reg == SIZE_BYTE
        && write_reg && !addr_reg[0] && is_external(space)
        |-> addr_data_oe == 16'hff00 && addr_data_out[15:8] == wdata_reg[7:0])
        else $error("even byte not on the upper lanes");

    a_long_on_narrow: assert property (@(posedge mclk) disable iff (!rst_b)
        state_reg == ST_BEAT && width == WIDTH_8 && size_reg == SIZE_LONG
        |-> last_reg == 2'd3)
        else $error("longword on 8-bit bus not split into four");

    a_hi_bits_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
        !dram_strobe_en |-> dram_addr_hi == 2'b00)
        else $error("address bits 23..22 driven outside dram");

    a_periph_wrap: assert property (@(posedge mclk) disable iff (!rst_b)
        periph_sel |-> onchip_addr[15:9] == 7'h00)
        else $error("peripheral address exceeds 512 bytes");

    a_cs_stable: assert property (@(posedge mclk) disable iff (!rst_b)
        state_reg == ST_SETUP && beat_reg != 2'd0
        |=> $stable(area_select_n))
        else $error("area select changed inside a split access");

    a_done_after_ack: assert property (@(posedge mclk) disable iff (!rst_b)
        req_done |-> $past(beat_ack) && $past(beat_reg) == $past(last_reg))
        else $error("done before the last beat was acknowledged");

endmodule
`default_nettype wire

/* File: area_decode_consts.svh */
// address field positions, area codes and reset values of the area decoder
`ifndef AREA_DECODE_CONSTS_SVH
`define AREA_DECODE_CONSTS_SVH

`define WIDTH_BIT        27
`define AREA_MSB         26
`define AREA_LSB         24
`define DRAM_HI_MSB      23
`define DRAM_HI_LSB      22
`define EXT_ADDR_W       22
`define PERIPH_WIDTH_BIT 8
`define MUXIO_WIDTH_BIT  14
`define ROM_ADDR_W       16
`define PERIPH_ADDR_W    9
`define RAM_ADDR_W       12

`define AREA_ROM         3'h0
`define AREA_DRAM        3'h1
`define AREA_PERIPH      3'h5
`define AREA_MUXIO       3'h6
`define AREA_RAM         3'h7

`define MODE_EXT8        3'h0
`define MODE_EXT16       3'h1
`define MODE_ROM         3'h2

`define CS_IDLE          8'hff

`endif

/* File: area_decode_pkg.sv */
// types shared by the area decoder modules
package area_decode_pkg;

    typedef enum logic [2:0] {
        SPACE_EXT,
        SPACE_DRAM,
        SPACE_MUXIO,
        SPACE_ROM,
        SPACE_PERIPH,
        SPACE_RAM
    } space_type;

    typedef enum logic [1:0] {
        WIDTH_8,
        WIDTH_16,
        WIDTH_32
    } width_type;

    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_WORD,
        SIZE_LONG
    } size_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_BEAT
    } state_type;

endpackage

/* File: area_classify.sv */
// classifies an address into area, space kind and bus width
`timescale 1ns/1ns
`default_nettype none
`include "area_decode_consts.svh"

module area_classify
    import area_decode_pkg::*;
(
    // address, top four bits already dropped
    input  wire logic [27:0] addr,
    // configuration
    input  wire logic [2:0]  boot_config_pins,
    input  wire logic        dram_area_enable,
    input  wire logic        muxed_io_enable,
    // result
    output logic      [2:0]  area,
    output space_type        space,
    output width_type        width
);

    logic wide;
    assign wide = addr[`WIDTH_BIT];

    always_comb begin
        area  = addr[`AREA_MSB:`AREA_LSB];
        space = SPACE_EXT;
        width = wide ? WIDTH_16 : WIDTH_8;
        if (area == `AREA_ROM) begin
            if (boot_config_pins == `MODE_ROM) begin
                space = SPACE_ROM;
                width = WIDTH_32;
            end else begin
                // unlisted codes fall back to the low pin choosing width
                width = boot_config_pins[0] ? WIDTH_16 : WIDTH_8;
            end
        end else if (area == `AREA_DRAM) begin
            if (dram_area_enable) begin
                space = SPACE_DRAM;
            end
        end else if (area == `AREA_PERIPH) begin
            if (!wide) begin
                space = SPACE_PERIPH;
                width = addr[`PERIPH_WIDTH_BIT] ? WIDTH_16 : WIDTH_8;
            end
        end else if (area == `AREA_MUXIO) begin
            if (!wide) begin
                space = muxed_io_enable ? SPACE_MUXIO : SPACE_EXT;
                width = addr[`MUXIO_WIDTH_BIT] ? WIDTH_16 : WIDTH_8;
            end
        end else if (area == `AREA_RAM) begin
            if (wide) begin
                space = SPACE_RAM;
                width = WIDTH_32;
            end
        end
    end

endmodule
`default_nettype wire

/* File: lane_router.sv */
// places the write data of one beat onto the address/data lanes
`timescale 1ns/1ns
`default_nettype none

module lane_router
    import area_decode_pkg::*;
(
    // beat description
    input  wire width_type   width,
    input  wire size_type    size,
    input  wire logic        addr_lsb,
    input  wire logic [1:0]  remain,
    input  wire logic [31:0] wdata,
    // lanes
    output logic      [15:0] lane_out,
    output logic      [1:0]  lane_mask
);

    always_comb begin
        lane_out  = 16'h0000;
        lane_mask = 2'b00;
        case (width)
            WIDTH_8: begin
                lane_out  = {8'h00, wdata[{remain, 3'b000} +: 8]};
                lane_mask = 2'b01;
            end
            WIDTH_16: begin
                if (size == SIZE_BYTE) begin
                    // even byte rides the upper lane
                    lane_out  = addr_lsb ? {8'h00, wdata[7:0]}
                                         : {wdata[7:0], 8'h00};
                    lane_mask = addr_lsb ? 2'b01 : 2'b10;
                end else begin
                    lane_out  = remain[0] ? wdata[31:16] : wdata[15:0];
                    lane_mask = 2'b11;
                end
            end
            default: begin
                lane_out  = wdata[15:0];
                lane_mask = 2'b11;
            end
        endcase
    end

endmodule
`default_nettype wire

/* File: ext_mem_model.sv */
// behavioural model of external memories and on-chip slaves
`timescale 1ns/1ns
`default_nettype none

module ext_mem_model (
    // clock and pace
    input  wire logic        mclk,
    input  wire logic        slow,
    // from the decoder
    input  wire logic [7:0]  area_select_n,
    input  wire logic [21:0] ext_addr,
    input  wire logic        dram_strobe_en,
    input  wire logic [2:0]  onchip_sel,
    input  wire logic [15:0] onchip_addr,
    // answers
    output logic             beat_ack,
    output logic      [15:0] addr_data_in,
    output logic      [31:0] onchip_rdata
);
    logic        act;
    logic [1:0]  ph_reg;
    logic [15:0] last_reg;
    assign act = (area_select_n != 8'hff) | dram_strobe_en | (|onchip_sel);
    always_ff @(posedge mclk) ph_reg <= act ? ph_reg + 2'h1 : 2'h0;
    // the setup cycle between beats falls on an odd phase when fast and on phase 0 when slow, so no stray ack
    assign beat_ack = act & (slow ? ph_reg == 2'h3 : !ph_reg[0]);
    always_ff @(posedge mclk) last_reg <= addr_data_in;
    // released lanes flip instead of holding, so a stale read shows up
    assign addr_data_in = act ? {ext_addr[7:0] ^ 8'h3c, ext_addr[7:0]}
                              : ~last_reg;
    assign onchip_rdata = {onchip_addr, ~onchip_addr};
endmodule

`default_nettype wire

/* File: tb_top.sv */
// self-checking bench of the area decoder
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import area_decode_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic        slow = 1'b0;
    logic        dram_area_enable = 1'b0;
    logic        muxed_io_enable = 1'b0;
    logic [2:0]  boot_config_pins = 3'h1;
    logic [31:0] req_addr = 32'h0;
    logic [31:0] req_wdata = 32'h0;
    size_type    req_size = SIZE_BYTE;
    logic        clk_en = 1'b1;
    logic        req_busy, req_done, dram_strobe_en, muxed_io_cycle;
    logic        bus_write, bw;
    logic [1:0]  dram_addr_hi, dh;
    logic [31:0] onchip_wdata, ow;
    logic        rom_sel, periph_sel, ram_sel, beat_ack;
    logic [1:0]  lane_active, ln;
    logic [7:0]  area_select_n, cs;
    logic [15:0] addr_data_out, addr_data_oe, addr_data_in, onchip_addr;
    logic [21:0] ext_addr, ea;
    logic [31:0] req_rdata, onchip_rdata, rd;
    logic [4:0]  fl;
    logic [3:0]  nb;
    logic [15:0] oa, ad, oe;
    int          errors = 0;
    int          comparisons = 0;
    int          cyc = 0;

    area_decoder_bus_width dut_u (
        .mclk, .rst_b, .clk_en, .req_valid, .req_addr, .req_size,
        .req_write, .req_wdata, .req_busy, .req_done, .req_rdata,
        .boot_config_pins, .dram_area_enable, .muxed_io_enable,
        .area_select_n, .ext_addr, .dram_addr_hi, .dram_strobe_en,
        .muxed_io_cycle, .bus_write, .lane_active, .addr_data_out,
        .addr_data_oe, .addr_data_in, .beat_ack, .rom_sel, .periph_sel,
        .ram_sel, .onchip_addr, .onchip_wdata, .onchip_rdata
    );
    ext_mem_model bus_u (
        .mclk, .slow, .area_select_n, .ext_addr, .dram_strobe_en,
        .onchip_sel({rom_sel, periph_sel, ram_sel}), .onchip_addr,
        .beat_ack, .addr_data_in, .onchip_rdata
    );

    always #4 mclk = ~mclk;

    task automatic give_verdict();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cfg(input logic [2:0] m, input logic de, input logic me);
        @(posedge mclk);
        boot_config_pins <= m;
        dram_area_enable <= de;
        muxed_io_enable  <= me;
    endtask

    // one request; records what the bus showed until done
    task automatic xfer(input logic [31:0] a, input size_type s,
                        input logic w, input logic [31:0] d);
        int n;
        @(posedge mclk);
        req_valid <= 1'b1;
        req_addr  <= a;
        req_size  <= s;
        req_write <= w;
        req_wdata <= d;
        @(posedge mclk);
        req_valid <= 1'b0;
        {cs, nb, ln, fl} = {8'hff, 11'h0};
        for (n = 0; n < 100 && req_done !== 1'b1; n++) begin
            @(negedge mclk);
            cs = cs & area_select_n;
            fl = fl | {dram_strobe_en, muxed_io_cycle, rom_sel, periph_sel,
                       ram_sel};
            if (beat_ack === 1'b1 && req_busy === 1'b1) begin
                if (nb == 4'h0)
                    {ea, oa, ad, oe, dh, bw, ow} = {ext_addr, onchip_addr,
                        addr_data_out, addr_data_oe, dram_addr_hi,
                        bus_write, onchip_wdata};
                nb = nb + 4'h1;
                ln = ln | lane_active;
            end
        end
        chk(req_done, 64'h1);
        rd = req_rdata;
    endtask

    // a request while frozen must not be taken
    task automatic t_freeze();
        @(posedge mclk);
        clk_en    <= 1'b0;
        req_valid <= 1'b1;
        repeat (3) @(posedge mclk);
        req_valid <= 1'b0;
        clk_en    <= 1'b1;
        @(negedge mclk);
        chk({req_busy, area_select_n}, 9'h0ff);
    endtask

    task automatic t_areas();
        int k;
        for (k = 0; k < 8; k++) begin
            xfer({5'h1f, k[2:0], 24'h10}, SIZE_BYTE, 1'b0, 32'h0);
            chk(cs, k == 7 ? 8'hff : 8'(~(8'h01 << k)));
        end
    endtask

    task automatic t_onchip();
        cfg(3'h2, 1'b0, 1'b0);
        xfer(32'h00ab1234, SIZE_LONG, 1'b0, 32'h0);
        chk({cs, fl, nb, oa}, {8'hff, 5'h04, 4'h1, 16'h1234});
        chk(rd, 32'h1234edcb);
        xfer(32'h05abc1f3, SIZE_WORD, 1'b0, 32'h0);
        chk({cs, fl, nb, rd[15:0]}, {8'hff, 5'h02, 4'h1, 16'hfe0c});
        xfer(32'h0f000abc, SIZE_LONG, 1'b0, 32'h0);
        chk({cs, fl, rd}, {8'hff, 5'h01, 32'h0abcf543});
        xfer(32'h0f000100, SIZE_LONG, 1'b1, 32'h12345678);
        chk({cs, fl, bw, ow}, {8'hff, 5'h01, 1'b0, 32'h12345678});
    endtask

    task automatic t_width();
        cfg(3'h1, 1'b0, 1'b0);
        xfer(32'h02c00034, SIZE_LONG, 1'b0, 32'h0);
        chk({nb, ln, ea, rd}, {4'h4, 2'h1, 22'h34, 32'h34353637});
        chk(dh, 64'h0);
        xfer(32'h0ac00034, SIZE_LONG, 1'b0, 32'h0);
        chk({nb, ln, ea, rd}, {4'h2, 2'h3, 22'h34, 32'h08340a36});
        xfer(32'h0a000035, SIZE_BYTE, 1'b0, 32'h0);
        chk({ln, rd}, {2'h1, 32'h35});
        xfer(32'h02000034, SIZE_WORD, 1'b0, 32'h0);
        chk({nb, ln, rd}, {4'h2, 2'h1, 32'h3435});
        xfer(32'h06004034, SIZE_WORD, 1'b0, 32'h0);
        chk({cs, nb}, {8'hbf, 4'h1});
        xfer(32'h0d000034, SIZE_WORD, 1'b0, 32'h0);
        chk({cs, nb}, {8'hdf, 4'h1});
        xfer(32'h07000034, SIZE_WORD, 1'b0, 32'h0);
        chk({cs, nb}, {8'h7f, 4'h2});
    endtask

    task automatic t_modes();
        cfg(3'h1, 1'b1, 1'b1);
        xfer(32'h01c00034, SIZE_BYTE, 1'b0, 32'h0);
        chk({cs, fl[4]}, {8'hff, 1'b1});
        chk(dh, 64'h3);
        xfer(32'h06000034, SIZE_BYTE, 1'b0, 32'h0);
        chk({cs, fl[3]}, {8'hbf, 1'b1});
        @(posedge mclk);
        slow <= 1'b1;
        xfer(32'h02000034, SIZE_LONG, 1'b1, 32'hcafe1234);
        chk({nb, ad[7:0], oe}, {4'h4, 8'hca, 16'h00ff});
        chk(bw, 64'h1);
        xfer(32'h0a000034, SIZE_BYTE, 1'b1, 32'h5a);
        chk({ad[15:8], oe}, {8'h5a, 16'hff00});
    endtask

    // a hung handshake already ends each xfer after 100 cycles; this stops the whole run at cycle 3000
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        @(negedge mclk);
        chk({req_busy, area_select_n}, 9'h0ff);
        t_freeze();
        t_areas();
        t_onchip();
        t_width();
        t_modes();
        give_verdict();
    end
endmodule

`default_nettype wire
